// >>> design/lpop_top.sv
// logic program engine with operand pools, result routing and APB registers
`timescale 1ns/1ps
module lpop_top
  import lpop_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // field inputs
  input wire logic [7:0] DIO_IN_A,
  input wire logic [7:0] DIO_IN_B,
  input wire logic [7:0] TIMER_OUT,
  input wire logic [63:0] MODULE_SIG,
  // program outputs
  output logic [14:0] RESULT_OUT,
  output logic [7:0] TIMER_IN1,
  output logic [7:0] TIMER_IN2,
  output logic [1:0] PUMP_CTRL,
  output logic ACTION_CALL,
  output logic [7:0] ACTION_ID,
  // routed result bits
  output logic [7:0] DOUT_LINE,
  output logic [3:0] RELAY_OUT,
  output logic ANALOG_SRC,
  output logic BARGRAPH_SRC,
  output logic [1:0] CALC_SRC
);

  logic [15:0] prog_ff [PROG_DEPTH];
  logic [5:0] map_ff [MAP_DEPTH];
  logic [3:0] route_ff [ROUTE_DEPTH];
  logic run_ff;
  logic [6:0] pc_ff;
  logic [6:0] nxt_pc;
  logic ir_ff;
  logic nxt_ir;
  logic taken_ff;
  logic nxt_taken;
  lpop_mode_t mode_ff;
  lpop_mode_t nxt_mode;
  logic [14:0] res_ff;
  logic [14:0] nxt_res;
  logic [14:0] mem_ff;
  logic [14:0] nxt_mem;
  logic [7:0] tin1_ff;
  logic [7:0] nxt_tin1;
  logic [7:0] tin2_ff;
  logic [7:0] nxt_tin2;
  logic [1:0] pump_ff;
  logic [1:0] nxt_pump;
  logic call_ff;
  logic nxt_call;
  logic [7:0] act_ff;
  logic [7:0] nxt_act;
  logic [15:0] pass_ff;
  logic [15:0] nxt_pass;
  logic [15:0] route_out_ff;
  logic [31:0] rdata_ff;

  // apb decode
  wire logic setup_ph = PSEL & ~PENABLE;
  wire logic wr_en = PSEL & PENABLE & PWRITE;
  wire logic is_map = PADDR[9:8] == REG_MAP_BASE[9:8];
  wire logic is_prog = PADDR[9] == REG_PROG_BASE[9];
  wire logic is_ctrl = PADDR == REG_CTRL;
  wire logic is_low = (PADDR[9:5] == 5'h00) & (PADDR[1:0] == 2'h0);
  wire logic ro_low = is_low & ~is_ctrl & (PADDR != REG_ROUTE_LO) &
                      (PADDR != REG_ROUTE_HI);
  wire logic aligned = PADDR[1:0] == 2'h0;
  wire logic mapped = is_low | ((is_map | is_prog) & aligned);
  wire logic [5:0] map_idx = PADDR[7:2];
  wire logic [6:0] prog_idx = PADDR[8:2];
  wire logic [31:0] route_lo_w = {route_ff[7], route_ff[6], route_ff[5],
                                  route_ff[4], route_ff[3], route_ff[2],
                                  route_ff[1], route_ff[0]};
  wire logic [31:0] route_hi_w = {route_ff[15], route_ff[14], route_ff[13],
                                  route_ff[12], route_ff[11], route_ff[10],
                                  route_ff[9], route_ff[8]};

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (is_prog)
      rd_mux = {16'h0000, prog_ff[prog_idx]};
    else if (is_map)
      rd_mux = {26'h0000000, map_ff[map_idx]};
    else
      case (PADDR)
        REG_CTRL: rd_mux = {31'h00000000, run_ff};
        REG_STATUS: rd_mux = {16'h0000, 1'b0, pc_ff, 6'h00, ir_ff, run_ff};
        REG_RESULT: rd_mux = {14'h0000, pump_ff, 1'b0, res_ff};
        REG_MEMFLAG: rd_mux = {17'h00000, mem_ff};
        REG_TIMERS: rd_mux = {16'h0000, tin2_ff, tin1_ff};
        REG_ROUTE_LO: rd_mux = route_lo_w;
        REG_ROUTE_HI: rd_mux = route_hi_w;
        REG_PASSCNT: rd_mux = {16'h0000, pass_ff};
        default: rd_mux = 32'h0000_0000;
      endcase
  end

  // read data is captured in setup, so every access has one wait-free phase
  assign PREADY = PSEL & PENABLE;
  assign PSLVERR = PSEL & PENABLE & (~mapped | (PWRITE & ro_low));
  assign PRDATA = rdata_ff;

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      rdata_ff <= 32'h0000_0000;
    else if (setup_ph)
      rdata_ff <= PWRITE ? 32'h0000_0000 : rd_mux;
  end

  // software writes: program, input map, routing and run control
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      run_ff <= CTRL_RUN_RST;
      for (int i = 0; i < PROG_DEPTH; i++)
        prog_ff[i] <= PROG_RST;
      for (int i = 0; i < MAP_DEPTH; i++)
        map_ff[i] <= MAP_RST;
      for (int i = 0; i < ROUTE_DEPTH; i++)
        route_ff[i] <= ROUTE_RST;
    end
    else if (wr_en && mapped)
    begin
      if (is_prog)
        prog_ff[prog_idx] <= PWDATA[15:0];
      else if (is_map)
        // [R1] module signal mapping
        map_ff[map_idx] <= PWDATA[5:0];
      else if (is_ctrl)
        run_ff <= PWDATA[0];
      else if (PADDR == REG_ROUTE_LO)
        for (int i = 0; i < 8; i++)
          route_ff[i] <= PWDATA[4*i +: 4];
      else if (PADDR == REG_ROUTE_HI)
        for (int i = 0; i < 8; i++)
          route_ff[i + 8] <= PWDATA[4*i +: 4];
    end
  end

  // input pool lookup; unassigned and reserved IDs read 0
  function automatic logic pool_in(input logic [7:0] id);
    logic v;
    v = 1'b0;
    // [R3] result readback
    if (id >= ID_RES_LO && id <= ID_RES_HI)
      v = res_ff[4'(id - ID_RES_LO)];
    // [R4] memory readback
    else if (id >= ID_MEM_LO && id <= ID_MEM_HI)
      v = mem_ff[4'(id - ID_MEM_LO)];
    else if (id >= ID_TMR_LO && id <= ID_TMR_HI)
      v = TIMER_OUT[3'(id - ID_TMR_LO)];
    // [R2] board input lines
    else if (id >= ID_DIOA_LO && id <= ID_DIOA_HI)
      v = DIO_IN_A[3'(id - ID_DIOA_LO)];
    else if (id >= ID_DIOB_LO && id <= ID_DIOB_HI)
      v = DIO_IN_B[3'(id - ID_DIOB_LO)];
    else if (id == ID_PUMP1 || id == ID_PUMP2)
      v = pump_ff[id == ID_PUMP2];
    // [R15] constant sources
    else if (id == ID_ON)
      v = 1'b1;
    else if (id == ID_OFF)
      v = 1'b0;
    // [R1] mapped module signals
    else if (id >= ID_MOD_LO && id <= ID_MOD_HI)
      v = MODULE_SIG[map_ff[6'(id - ID_MOD_LO)]];
    return v;
  endfunction : pool_in

  wire logic [15:0] word = prog_ff[pc_ff];
  wire logic is_op = word[15];
  wire logic is_id = ~word[15] & (word != 16'h0000) & (word <= 16'h0080);
  wire logic [7:0] wid = word[7:0];
  // looked up inside a process so that changes of the pool sources are seen
  logic in_val;
  // a program with no end code wraps after the last step
  wire logic pass_end = (is_op & (word == OP_END)) |
                        (pc_ff == 7'(PROG_DEPTH - 1));

  // one program step per clock
  always_comb
  begin
    in_val = pool_in(wid);
    nxt_pc = pc_ff + 7'h01;
    nxt_ir = ir_ff;
    nxt_mode = mode_ff;
    nxt_taken = taken_ff;
    nxt_res = res_ff;
    nxt_mem = mem_ff;
    nxt_tin1 = tin1_ff;
    nxt_tin2 = tin2_ff;
    nxt_pump = pump_ff;
    nxt_call = 1'b0;
    nxt_act = act_ff;
    nxt_pass = pass_ff;
    if (!run_ff)
    begin
      nxt_pc = 7'h00;
      nxt_ir = 1'b0;
      nxt_mode = MD_NONE;
    end
    else
    begin
      if (is_op)
        // [R13] operator decode
        case (word)
          OP_OR: nxt_mode = MD_OR;
          OP_AND: nxt_mode = MD_AND;
          OP_INV: nxt_ir = ~ir_ff;
          OP_STORE: nxt_mode = MD_STORE;
          OP_CLEAR: nxt_ir = 1'b0;
          OP_SET: nxt_ir = 1'b1;
          OP_LOAD: nxt_mode = MD_LOAD;
          OP_IF: nxt_mode = MD_IF1;
          OP_CALL: nxt_mode = MD_CALL;
          default: nxt_mode = MD_NONE;
        endcase
      // [R8] operand pool chosen by mode
      else if (is_id)
        case (mode_ff)
          // [R9] OR chain
          MD_OR: nxt_ir = ir_ff | in_val;
          MD_AND: nxt_ir = ir_ff & in_val;
          // [R11] load operand
          MD_LOAD:
          begin
            nxt_ir = in_val;
            nxt_mode = MD_NONE;
          end
          // [R14] two-way select
          MD_IF1:
          begin
            nxt_taken = ir_ff;
            if (ir_ff)
              nxt_ir = in_val;
            nxt_mode = MD_IF2;
          end
          MD_IF2:
          begin
            if (!taken_ff)
              nxt_ir = in_val;
            nxt_mode = MD_NONE;
          end
          MD_CALL:
          begin
            nxt_call = ir_ff;
            nxt_act = ir_ff ? wid : act_ff;
            nxt_mode = MD_NONE;
          end
          // [R10] store to output pool
          MD_STORE:
          begin
            nxt_mode = MD_NONE;
            // [R3] result bits
            if (wid >= ID_RES_LO && wid <= ID_RES_HI)
              nxt_res[4'(wid - ID_RES_LO)] = ir_ff;
            // [R4] memory flags
            else if (wid >= ID_MEM_LO && wid <= ID_MEM_HI)
              nxt_mem[4'(wid - ID_MEM_LO)] = ir_ff;
            // [R5] timer inputs
            else if (wid >= ID_TMR_LO && wid <= ID_TMR_HI)
              nxt_tin1[3'(wid - ID_TMR_LO)] = ir_ff;
            else if (wid >= ID_DIOA_LO && wid <= ID_DIOA_HI)
              nxt_tin2[3'(wid - ID_DIOA_LO)] = ir_ff;
            // [R6] pump controls
            else if (wid == ID_PUMP1 || wid == ID_PUMP2)
              nxt_pump[wid == ID_PUMP2] = ir_ff;
          end
          default: nxt_mode = MD_NONE;
        endcase
      // [R16] restart pass with cleared result
      if (pass_end)
      begin
        nxt_pc = 7'h00;
        nxt_ir = 1'b0;
        nxt_mode = MD_NONE;
        nxt_pass = pass_ff + 16'h0001;
      end
    end
  end

  // [R12] latches hold through memory and result flops across passes
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      pc_ff <= 7'h00;
      ir_ff <= 1'b0;
      mode_ff <= MD_NONE;
      taken_ff <= 1'b0;
      res_ff <= 15'h0000;
      mem_ff <= 15'h0000;
      tin1_ff <= 8'h00;
      tin2_ff <= 8'h00;
      pump_ff <= 2'h0;
      call_ff <= 1'b0;
      act_ff <= 8'h00;
      pass_ff <= 16'h0000;
    end
    else
    begin
      pc_ff <= nxt_pc;
      ir_ff <= nxt_ir;
      mode_ff <= nxt_mode;
      taken_ff <= nxt_taken;
      res_ff <= nxt_res;
      mem_ff <= nxt_mem;
      tin1_ff <= nxt_tin1;
      tin2_ff <= nxt_tin2;
      pump_ff <= nxt_pump;
      call_ff <= nxt_call;
      act_ff <= nxt_act;
      pass_ff <= nxt_pass;
    end
  end

  // [R7] route selection, 0 selects nothing
  logic [15:0] route_nxt;
  always_comb
  begin
    for (int i = 0; i < ROUTE_DEPTH; i++)
      route_nxt[i] = (route_ff[i] != 4'h0) &
                     res_ff[4'(route_ff[i] - 4'h1)];
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      route_out_ff <= 16'h0000;
    else
      route_out_ff <= route_nxt;
  end

  assign RESULT_OUT = res_ff;
  assign TIMER_IN1 = tin1_ff;
  assign TIMER_IN2 = tin2_ff;
  assign PUMP_CTRL = pump_ff;
  assign ACTION_CALL = call_ff;
  assign ACTION_ID = act_ff;
  assign DOUT_LINE = route_out_ff[7:0];
  assign RELAY_OUT = route_out_ff[11:8];
  assign ANALOG_SRC = route_out_ff[12];
  assign BARGRAPH_SRC = route_out_ff[13];
  assign CALC_SRC = route_out_ff[15:14];

endmodule : lpop_top

// >>> design/lpop_pkg.sv
// constants, operator codes and register map of the logic program engine
//
// Behaviour
// [R1] IDs 1 to 64 read fixed sources and IDs 65 to 128 read software-mapped module signals.
// [R2] Input IDs 41 to 48 read board A lines 1 to 8 and IDs 49 to 56 read board B lines 1 to 8.
// [R3] Output IDs 1 to 15 are result bits, driven out and readable through the same input IDs.
// [R4] Output IDs 16 to 30 are memory flags, readable through the same input IDs.
// [R5] Output IDs 31 to 38 drive timer first inputs and IDs 41 to 48 drive timer second inputs.
// [R6] Output IDs 57 and 58 drive the two pump control bits, which are driven out.
// [R7] Each result bit can be routed to digital lines, relays, analog, bargraph and calculator.
// [R8] A positive program word is a signal ID whose pool is chosen by the preceding operator.
// [R9] Code -2 ORs each following input into the intermediate result, which starts at 0.
// [R10] Code -5 writes the intermediate result into the output named by the following ID.
// [R11] Code -9 loads the intermediate result from the input named by the following ID.
// [R12] The operators suffice to build a set-dominant latch from a stored program.
// [R13] Codes -1 nop, -3 AND, -4 invert, -6 clear, -7 end, -8 set, -11 call action if true; the code's -1 also cancels the pending operator mode.
// [R14] Code -10 takes two input IDs and loads the first if the result is true, else the second.
// [R15] Input ID 63 always reads 1 and input ID 64 always reads 0.
// [R16] The program runs repeatedly from step 0 to the end code, the result cleared each pass.
package lpop_pkg;
  localparam int PROG_DEPTH = 128;
  localparam int MAP_DEPTH = 64;
  localparam int ROUTE_DEPTH = 16;
  // operator codes as 16-bit two's complement words
  localparam logic [15:0] OP_NOP = 16'hFFFF;
  localparam logic [15:0] OP_OR = 16'hFFFE;
  localparam logic [15:0] OP_AND = 16'hFFFD;
  localparam logic [15:0] OP_INV = 16'hFFFC;
  localparam logic [15:0] OP_STORE = 16'hFFFB;
  localparam logic [15:0] OP_CLEAR = 16'hFFFA;
  localparam logic [15:0] OP_END = 16'hFFF9;
  localparam logic [15:0] OP_SET = 16'hFFF8;
  localparam logic [15:0] OP_LOAD = 16'hFFF7;
  localparam logic [15:0] OP_IF = 16'hFFF6;
  localparam logic [15:0] OP_CALL = 16'hFFF5;
  // signal ID ranges
  localparam logic [7:0] ID_RES_LO = 8'h01;
  localparam logic [7:0] ID_RES_HI = 8'h0F;
  localparam logic [7:0] ID_MEM_LO = 8'h10;
  localparam logic [7:0] ID_MEM_HI = 8'h1E;
  localparam logic [7:0] ID_TMR_LO = 8'h1F;
  localparam logic [7:0] ID_TMR_HI = 8'h26;
  localparam logic [7:0] ID_DIOA_LO = 8'h29;
  localparam logic [7:0] ID_DIOA_HI = 8'h30;
  localparam logic [7:0] ID_DIOB_LO = 8'h31;
  localparam logic [7:0] ID_DIOB_HI = 8'h38;
  localparam logic [7:0] ID_PUMP1 = 8'h39;
  localparam logic [7:0] ID_PUMP2 = 8'h3A;
  localparam logic [7:0] ID_ON = 8'h3F;
  localparam logic [7:0] ID_OFF = 8'h40;
  localparam logic [7:0] ID_MOD_LO = 8'h41;
  localparam logic [7:0] ID_MOD_HI = 8'h80;
  // register byte offsets
  localparam logic [9:0] REG_CTRL = 10'h000;
  localparam logic [9:0] REG_STATUS = 10'h004;
  localparam logic [9:0] REG_RESULT = 10'h008;
  localparam logic [9:0] REG_MEMFLAG = 10'h00C;
  localparam logic [9:0] REG_TIMERS = 10'h010;
  localparam logic [9:0] REG_ROUTE_LO = 10'h014;
  localparam logic [9:0] REG_ROUTE_HI = 10'h018;
  localparam logic [9:0] REG_PASSCNT = 10'h01C;
  localparam logic [9:0] REG_MAP_BASE = 10'h100;
  localparam logic [9:0] REG_PROG_BASE = 10'h200;
  localparam logic CTRL_RUN_RST = 1'b0;
  localparam logic [15:0] PROG_RST = 16'h0000;
  localparam logic [5:0] MAP_RST = 6'h00;
  localparam logic [3:0] ROUTE_RST = 4'h0;
  typedef enum {MD_NONE, MD_OR, MD_AND, MD_STORE, MD_LOAD, MD_IF1, MD_IF2,
                MD_CALL} lpop_mode_t;
endpackage : lpop_pkg

// >>> dv/lpop_props.sv
// checker on the engine's apb and action ports
`timescale 1ns/1ps
module lpop_props
  import lpop_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // action outputs
  input wire logic ACTION_CALL,
  input wire logic [7:0] ACTION_ID
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  // gap between the status words and the map table
  wire hole = (PADDR >= 10'h020) && (PADDR < 10'h100);
  wire ro_reg = (PADDR == REG_STATUS) || (PADDR == REG_PASSCNT);
  wire prog_word = (PADDR >= REG_PROG_BASE) && (PADDR[1:0] == 2'h0);
  sequence s_acc;
    PSEL && PENABLE;
  endsequence
  sequence s_rd;
    PSEL && PENABLE && !PWRITE;
  endsequence
  sequence s_wr;
    PSEL && PENABLE && PWRITE;
  endsequence
  a_ready_access: assert property (PREADY == (PSEL && PENABLE))
    else $error("pready differs from access phase");
  a_hole_err: assert property (s_acc ##0 hole |-> PSLVERR)
    else $error("unmapped access without error");
  a_hole_zero: assert property (s_rd ##0 hole |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_ro_write: assert property (s_wr ##0 ro_reg |-> PSLVERR)
    else $error("read-only write accepted");
  a_prog_write: assert property (s_wr ##0 prog_word |-> !PSLVERR)
    else $error("program word write refused");
  a_err_idle: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
    else $error("error outside access phase");
  a_rdata_holds: assert property (s_acc |=> $stable(PRDATA))
    else $error("read data moved after access");
  a_call_pulse: assert property (ACTION_CALL |=> !ACTION_CALL)
    else $error("action call longer than one cycle");
  a_id_with_call: assert property ($changed(ACTION_ID) |-> ACTION_CALL)
    else $error("action id moved without call");
endmodule : lpop_props

bind lpop_top lpop_props u_props (.REF_CLK(REF_CLK), .RESETN(RESETN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .ACTION_CALL(ACTION_CALL), .ACTION_ID(ACTION_ID));

// >>> dv/lpop_field_model.sv
// field boards, module status lines and a stand-in timer bank
`timescale 1ns/1ps
module lpop_field_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels asked for by the bench
  input wire logic [7:0] set_a,
  input wire logic [7:0] set_b,
  input wire logic [63:0] set_mod,
  // timer first inputs from the engine
  input wire logic [7:0] tmr_in1,
  // field lines
  output logic [7:0] dio_a,
  output logic [7:0] dio_b,
  output logic [7:0] tmr_out,
  output logic [63:0] mod_sig
);
  // lines change only on the clock, as synchronised board inputs would
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dio_a <= 8'h00;
      dio_b <= 8'h00;
      tmr_out <= 8'h00;
      mod_sig <= 64'h0;
    end
    else
    begin
      dio_a <= set_a;
      dio_b <= set_b;
      // timer modes are out of scope: output follows input1 one cycle late
      tmr_out <= tmr_in1;
      mod_sig <= set_mod;
    end
  end
endmodule : lpop_field_model

// >>> dv/lpop_test.sv
// self-checking bench for the logic program engine
`timescale 1ns/1ps
module lpop_test;
  import lpop_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] set_a = 8'h00;
  logic [7:0] set_b = 8'h00;
  logic [63:0] set_mod = 64'h0;
  logic [31:0] prdata;
  logic pready, pslverr, act_call, analog, bargraph;
  logic [7:0] dio_a, dio_b, tmr_out, tmr_in1, tmr_in2, act_id, dout;
  logic [63:0] mod_sig;
  logic [14:0] result_out;
  logic [1:0] pump, calc;
  logic [3:0] relay;
  logic [31:0] rd_q;
  logic rd_e;
  logic [2:0] sr [5];
  int miscompares = 0;
  int n_checks = 0;
  int n_wait;

  always #2.5 ref_clk = ~ref_clk;

  lpop_field_model u_field (.clk(ref_clk), .rst_n(resetn), .set_a(set_a),
    .set_b(set_b), .set_mod(set_mod), .tmr_in1(tmr_in1), .dio_a(dio_a),
    .dio_b(dio_b), .tmr_out(tmr_out), .mod_sig(mod_sig));

  lpop_top dut (.REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DIO_IN_A(dio_a),
    .DIO_IN_B(dio_b), .TIMER_OUT(tmr_out), .MODULE_SIG(mod_sig),
    .RESULT_OUT(result_out), .TIMER_IN1(tmr_in1), .TIMER_IN2(tmr_in2),
    .PUMP_CTRL(pump), .ACTION_CALL(act_call), .ACTION_ID(act_id),
    .DOUT_LINE(dout), .RELAY_OUT(relay), .ANALOG_SRC(analog),
    .BARGRAPH_SRC(bargraph), .CALC_SRC(calc));

  task end_sim;
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; read data and error taken at the ready edge
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      miscompares++;
      end_sim();
    end
  endtask : apb

  // two completed passes guarantee the latest inputs were evaluated
  task settle;
    logic [15:0] p;
    int k;
    k = 0;
    apb(1'b0, REG_PASSCNT, 32'h0);
    p = rd_q[15:0];
    do
    begin
      apb(1'b0, REG_PASSCNT, 32'h0);
      k++;
    end
    while (16'(rd_q[15:0] - p) < 16'h0002 && k < 300);
    if (k >= 300)
    begin
      miscompares++;
      end_sim();
    end
  endtask : settle

  task go(input logic [15:0] w[$]);
    apb(1'b1, REG_CTRL, 32'h0);
    foreach (w[i])
      apb(1'b1, REG_PROG_BASE + 10'(4 * i), {16'h0000, w[i]});
    apb(1'b1, REG_CTRL, 32'h1);
    settle();
  endtask : go

  initial
  begin
    sr = '{3'b101, 3'b001, 3'b111, 3'b010, 3'b000};
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd_q, 32'h0);
    chk(result_out, 32'h0);
    apb(1'b0, 10'h040, 32'h0);
    chk(rd_q, 32'h0);
    chk(rd_e, 1'b1);
    apb(1'b1, REG_STATUS, 32'h0000_FFFF);
    chk(rd_e, 1'b1);
    // operators, constants, timers, pumps, flags, action; tail after end
    go('{OP_SET, OP_STORE, 16'h001F, OP_CLEAR, OP_INV, OP_STORE, 16'h002A,
      OP_AND, 16'h003F, OP_STORE, 16'h0039, OP_AND, 16'h0040, OP_NOP,
      OP_STORE, 16'h003A, OP_INV, OP_STORE, 16'h0010, OP_CALL, 16'h0005,
      OP_END, OP_SET, OP_STORE, 16'h003A});
    chk(tmr_in1, 8'h01);
    chk(tmr_in2, 8'h02);
    chk(pump, 2'b01);
    apb(1'b0, REG_RESULT, 32'h0);
    chk(rd_q, 32'h0001_0000);
    apb(1'b0, REG_MEMFLAG, 32'h0);
    chk(rd_q, 32'h0000_0001);
    chk(act_id, 8'h05);
    // the call repeats once per pass while the result before it is true
    n_wait = 0;
    while (act_call !== 1'b1 && n_wait < 100)
    begin
      @(posedge ref_clk);
      n_wait++;
    end
    chk(act_call, 1'b1);
    if (n_wait >= 100)
      end_sim();
    // mapped module signal, or over boards, timer readback, routing
    apb(1'b1, REG_MAP_BASE + 10'h008, 32'h0000_0028);
    apb(1'b1, REG_ROUTE_LO, 32'h0000_0004);
    apb(1'b1, REG_ROUTE_HI, 32'h0002_0000);
    set_b <= 8'h80;
    set_mod <= 64'h0000_0100_0000_0000;
    go('{OP_OR, 16'h0029, 16'h0038, OP_STORE, 16'h0002, OP_LOAD, 16'h001F,
      OP_STORE, 16'h0003, OP_LOAD, 16'h0043, OP_STORE, 16'h0004,
      OP_END});
    chk(result_out, 15'h000E);
    chk({relay, dout}, 12'h001);
    chk({calc, bargraph, analog}, 4'h1);
    // set-dominant latch on result 5, set on id 45, reset on id 46
    go('{OP_LOAD, 16'h002E, OP_IF, 16'h0040, 16'h0005, OP_STORE, 16'h001E,
      OP_LOAD, 16'h002D, OP_IF, 16'h003F, 16'h001E, OP_STORE, 16'h0005,
      OP_END});
    chk(result_out[4], 1'b0);
    foreach (sr[i])
    begin
      @(posedge ref_clk);
      set_a <= {2'b00, sr[i][1], sr[i][2], 4'h0};
      settle();
      chk(result_out[4], sr[i][0]);
    end
    apb(1'b0, REG_MEMFLAG, 32'h0);
    chk(rd_q[14], 1'b0);
    end_sim();
  end
endmodule : lpop_test
